// [rtl/lamp_strike_run_fault_sequencer.v]
// Functional notes
// - Delay mode runs the sweep timers, DAC held at run code, drive outputs inhibited.
// - Delay lasts 16384 ramp clock periods.
// - Sixteen sweeps: first delay, fifteen strike.
// - Delay starts on power-up and enable.
// - Strike DAC sawtooth run to five-times, fifteen sweeps.
// - Overvoltage freezes DAC only while asserted, also across sweep ends.
// - Strike ends: ignition to run, timeout fault.
// - Strike entered once per power/enable cycle.
// - Ignition returns fixed run frequency immediately.
// - Run window 8192 periods, under 8 faults.
// - Fault drives outputs low, filter node high.
// - Fault cleared only by enable or power cycle.
// - Ramp clock is twice lamp frequency.
// - Ignition after 8 complete current cycles.
// - Stopped external dimming clock causes fault.
`timescale 1ns/10ps
`include "lamp_seq_defs.vh"

module lamp_strike_run_fault_sequencer (
	input wire clk,
	input wire rst_n,
	input wire enable,
	input wire ramp_tick,
	input wire lamp_current_sense,
	input wire overvoltage_sense,
	input wire ext_dim_select,
	input wire dim_clk_edge,
	output reg drive_phase_first,
	output reg drive_phase_second,
	output reg brightness_filter_node,
	output reg use_dac_freq,
	output reg [7:0] dac_code,
	output reg [1:0] mode,
	output reg lamp_ignited
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	reg [1:0] mode_q;
	reg [1:0] mode_d;
	reg [14:0] period_q;
	reg [3:0] sweep_q;
	reg [13:0] window_q;
	reg [3:0] pulse_q;
	reg [7:0] dac_q;
	reg [6:0] step_q;
	reg [11:0] dim_wd_q;
	reg sense_q;
	reg phase_q;
	reg strike_done_q;

	wire pulse_rise;
	wire enough_pulses;
	wire sweep_end;
	wire dim_lost;
	wire hold_reset;
	wire delay_active;
	wire strike_active;
	wire run_active;
	wire sweep_active;
	wire window_end;
	wire strike_timeout;
	wire ignite_now;

	// Lamp cycles arrive as sense pulses; one rising edge per cycle
	assign pulse_rise = lamp_current_sense & ~sense_q;
	assign enough_pulses = (pulse_q == `IGNITE_PULSES);
	assign sweep_end = ramp_tick && (period_q == `SWEEP_RAMP_PERIODS - 15'h0001);
	assign dim_lost = ext_dim_select && (dim_wd_q == `DIM_CLK_TIMEOUT);

	// ----------------------------------------
	// Mode decode
	// ----------------------------------------
	// Enable low acts like a supply cycle
	assign hold_reset = !rst_n || !enable;
	assign delay_active = (mode_q == `MODE_DELAY);
	assign strike_active = (mode_q == `MODE_STRIKE);
	assign run_active = (mode_q == `MODE_RUN);
	assign sweep_active = delay_active || strike_active;

	// ----------------------------------------
	// Event decode
	// ----------------------------------------
	assign window_end = run_active && ramp_tick &&
		(window_q == `RUN_WINDOW_PERIODS - 14'h0001);
	assign strike_timeout = strike_active && sweep_end && (sweep_q == `SWEEP_COUNT_LAST);
	assign ignite_now = strike_active && enough_pulses;

	// ----------------------------------------
	// Mode sequencing
	// ----------------------------------------
	always @* begin
		mode_d = mode_q;
		case (mode_q)
			`MODE_DELAY: begin
				if (sweep_end) begin
					mode_d = `MODE_STRIKE;
				end
			end
			`MODE_STRIKE: begin
				if (ignite_now) begin
					mode_d = `MODE_RUN;
				end else if (strike_timeout) begin
					mode_d = `MODE_FAULT;
				end
			end
			`MODE_RUN: begin
				if (window_end && !enough_pulses) begin
					mode_d = `MODE_FAULT;
				end
			end
			`MODE_FAULT: begin
				mode_d = `MODE_FAULT;
			end
			default: begin
				mode_d = `MODE_FAULT;
			end
		endcase
		if (dim_lost && mode_q != `MODE_FAULT) begin
			mode_d = `MODE_FAULT;
		end
		// Strike only once; a strike return path would be a bug
		if (mode_d == `MODE_STRIKE && strike_done_q && mode_q != `MODE_STRIKE) begin
			mode_d = `MODE_FAULT;
		end
	end

	// ----------------------------------------
	// Mode register and sense history
	// ----------------------------------------
	always @(posedge clk) begin
		if (hold_reset) begin
			mode_q <= `MODE_DELAY;
			sense_q <= 1'b0;
		end else begin
			mode_q <= mode_d;
			sense_q <= lamp_current_sense;
		end
	end

	// ----------------------------------------
	// Drive phase toggle
	// ----------------------------------------
	// Two ramp ticks make one lamp cycle, so the phase flips every tick
	always @(posedge clk) begin
		if (hold_reset) begin
			phase_q <= 1'b0;
		end else if (ramp_tick) begin
			phase_q <= ~phase_q;
		end
	end

	// ----------------------------------------
	// Ramp period counting
	// ----------------------------------------
	// All timing runs off the ramp tick, at twice lamp frequency
	always @(posedge clk) begin
		if (hold_reset) begin
			period_q <= 15'h0000;
		end else if (sweep_end && sweep_active) begin
			period_q <= 15'h0000;
		end else if (ramp_tick && sweep_active) begin
			period_q <= period_q + 15'h0001;
		end
	end

	// ----------------------------------------
	// Sweep counting
	// ----------------------------------------
	// First sweep is the delay, the other fifteen strike
	always @(posedge clk) begin
		if (hold_reset) begin
			sweep_q <= 4'h0;
		end else if (sweep_end && sweep_active) begin
			sweep_q <= sweep_q + 4'h1;
		end
	end

	// ----------------------------------------
	// Lamp pulse counting
	// ----------------------------------------
	// Strike count starts clean, since delay keeps it cleared
	always @(posedge clk) begin
		if (hold_reset) begin
			pulse_q <= 4'h0;
		end else if (delay_active || ignite_now) begin
			pulse_q <= 4'h0;
		end else if (window_end) begin
			pulse_q <= 4'h0;
		end else if (pulse_rise && !enough_pulses) begin
			pulse_q <= pulse_q + 4'h1;
		end
	end

	// ----------------------------------------
	// Run window counting
	// ----------------------------------------
	always @(posedge clk) begin
		if (hold_reset) begin
			window_q <= 14'h0000;
		end else if (window_end) begin
			window_q <= 14'h0000;
		end else if (run_active && ramp_tick) begin
			window_q <= window_q + 14'h0001;
		end
	end

	// ----------------------------------------
	// Strike history
	// ----------------------------------------
	// Only a power or enable cycle clears it
	always @(posedge clk) begin
		if (hold_reset) begin
			strike_done_q <= 1'b0;
		end else if (strike_active) begin
			strike_done_q <= 1'b1;
		end
	end

	// ----------------------------------------
	// Strike DAC sawtooth
	// ----------------------------------------
	// Coarse steps keep the sweep within one sweep period
	always @(posedge clk) begin
		if (hold_reset) begin
			dac_q <= `DAC_RUN_CODE;
			step_q <= 7'h00;
		end else if (!strike_active) begin
			dac_q <= `DAC_RUN_CODE;
		end else if (overvoltage_sense) begin
			// Held across a sweep end too, the lamp keeps full voltage
			dac_q <= dac_q;
		end else if (sweep_end) begin
			dac_q <= `DAC_RUN_CODE;
			step_q <= 7'h00;
		end else if (ramp_tick) begin
			if (step_q == `DAC_STEP_PERIODS - 7'h01) begin
				step_q <= 7'h00;
				if (dac_q != `DAC_MAX_CODE) begin
					dac_q <= dac_q + 8'h01;
				end
			end else begin
				step_q <= step_q + 7'h01;
			end
		end
	end

	// ----------------------------------------
	// External dimming clock watchdog
	// ----------------------------------------
	always @(posedge clk) begin
		if (hold_reset || !ext_dim_select || dim_clk_edge) begin
			dim_wd_q <= 12'h000;
		end else if (ramp_tick && dim_wd_q != `DIM_CLK_TIMEOUT) begin
			dim_wd_q <= dim_wd_q + 12'h001;
		end
	end

	// ----------------------------------------
	// Drive outputs
	// ----------------------------------------
	// Drives stay low outside strike and run
	always @(posedge clk) begin
		if (hold_reset) begin
			drive_phase_first <= 1'b0;
			drive_phase_second <= 1'b0;
		end else if (mode_d == `MODE_STRIKE || mode_d == `MODE_RUN) begin
			drive_phase_first <= ~phase_q;
			drive_phase_second <= phase_q;
		end else begin
			drive_phase_first <= 1'b0;
			drive_phase_second <= 1'b0;
		end
	end

	// ----------------------------------------
	// Status outputs
	// ----------------------------------------
	always @(posedge clk) begin
		if (hold_reset) begin
			brightness_filter_node <= 1'b0;
			use_dac_freq <= 1'b0;
			dac_code <= `DAC_RUN_CODE;
			mode <= `MODE_DELAY;
			lamp_ignited <= 1'b0;
		end else begin
			mode <= mode_d;
			// Ignition drops DAC control in the same edge
			use_dac_freq <= (mode_d == `MODE_STRIKE);
			dac_code <= dac_q;
			lamp_ignited <= (mode_d == `MODE_RUN);
			brightness_filter_node <= (mode_d == `MODE_FAULT);
		end
	end

endmodule // lamp_strike_run_fault_sequencer

// [rtl/lamp_seq_defs.vh]
`ifndef LAMP_SEQ_DEFS_VH
`define LAMP_SEQ_DEFS_VH

// ----------------------------------------
// Sweep and period counts
// ----------------------------------------
`define DELAY_RAMP_PERIODS 15'h4000
`define SWEEP_RAMP_PERIODS 15'h4000
`define SWEEP_COUNT_LAST 4'hf
`define RUN_WINDOW_PERIODS 14'h2000
`define IGNITE_PULSES 4'h8

// ----------------------------------------
// Strike frequency code
// ----------------------------------------
`define DAC_RUN_CODE 8'h33
`define DAC_MAX_CODE 8'hff
`define DAC_STEP_PERIODS 7'h40

// ----------------------------------------
// Dimming clock watchdog, ramp periods
// ----------------------------------------
`define DIM_CLK_TIMEOUT 12'h800

// ----------------------------------------
// Mode codes
// ----------------------------------------
`define MODE_DELAY 2'h0
`define MODE_STRIKE 2'h1
`define MODE_RUN 2'h2
`define MODE_FAULT 2'h3

`endif

// [test/lamp_seq_checker.sv]
`timescale 1ns/10ps
module lamp_seq_checker (
	input wire clk,
	input wire rst_n,
	input wire enable,
	input wire overvoltage_sense,
	input wire drive_phase_first,
	input wire drive_phase_second,
	input wire brightness_filter_node,
	input wire use_dac_freq,
	input wire [7:0] dac_code,
	input wire [1:0] mode,
	input wire lamp_ignited
);
// ------------------------------
// Mode properties
// ------------------------------
default clocking @(posedge clk); endclocking
default disable iff (!rst_n);
AST_DELAY_INHIBIT: assert property (mode == 2'h0 |-> !drive_phase_first && !drive_phase_second)
	else $error("drive active in delay");
AST_STRIKE_DAC: assert property (mode == 2'h1 |-> use_dac_freq && dac_code >= 8'h33)
	else $error("strike not on dac");
AST_OV_FREEZE: assert property (mode == 2'h1 && overvoltage_sense && $past(overvoltage_sense) |=> mode != 2'h1 || $stable(dac_code))
	else $error("dac moved under overvoltage");
AST_RUN_FROM_STRIKE: assert property ($rose(mode == 2'h2) |-> $past(mode) == 2'h1)
	else $error("run entered not from strike");
AST_RUN_FIXED: assert property (mode == 2'h2 |-> !use_dac_freq && lamp_ignited)
	else $error("run not on fixed reference");
AST_NO_RESTRIKE: assert property (mode[1] && enable |=> mode[1])
	else $error("strike entered again");
AST_FAULT_OUT: assert property (mode == 2'h3 |-> brightness_filter_node && !drive_phase_first && !drive_phase_second)
	else $error("fault outputs wrong");
AST_FAULT_HOLD: assert property (mode == 2'h3 && enable |=> mode == 2'h3)
	else $error("fault left without enable cycle");
AST_EN_OFF: assert property (!enable |=> mode == 2'h0 && !drive_phase_first && !drive_phase_second)
	else $error("enable low not holding");
cover property ($rose(mode == 2'h1));
cover property ($rose(mode == 2'h2));
cover property (mode == 2'h3 ##1 !enable);
cover property (mode == 2'h1 && overvoltage_sense ##1 overvoltage_sense);
endmodule // lamp_seq_checker

bind lamp_strike_run_fault_sequencer lamp_seq_checker chk_i (.clk, .rst_n, .enable,
	.overvoltage_sense, .drive_phase_first, .drive_phase_second, .brightness_filter_node,
	.use_dac_freq, .dac_code, .mode, .lamp_ignited);

// [test/lamp_stage_model.sv]
`timescale 1ns/10ps
module lamp_stage_model (
	input wire clk,
	input wire lit,
	input wire drive_phase_second,
	output reg lamp_current_sense
);
// ------------------------------
// Lamp current follows drive phase
// ------------------------------
// Unlit lamp draws no current, so the sense stays low
initial lamp_current_sense = 1'b0;
always @(posedge clk) lamp_current_sense <= lit & drive_phase_second;
endmodule // lamp_stage_model

// [test/lamp_strike_run_fault_sequencer_tb_top.sv]
`timescale 1ns/10ps
module lamp_strike_run_fault_sequencer_tb_top;
reg clk = 1'b0, rst_n = 1'b0, enable = 1'b1, ov = 1'b0, lit = 1'b0;
reg dsel = 1'b0, dedge = 1'b0;
wire lcs, dpf, dps, bfn, udf, ign;
wire [7:0] dac;
wire [1:0] mode;
integer err_total = 0, n_tests = 0, i;
always #50 clk = ~clk;
// ------------------------------
// Design and lamp stage
// ------------------------------
lamp_stage_model pm (.clk(clk), .lit(lit), .drive_phase_second(dps), .lamp_current_sense(lcs));
lamp_strike_run_fault_sequencer dut (.clk(clk), .rst_n(rst_n), .enable(enable),
	.ramp_tick(1'b1), .lamp_current_sense(lcs), .overvoltage_sense(ov), .ext_dim_select(dsel),
	.dim_clk_edge(dedge), .drive_phase_first(dpf), .drive_phase_second(dps),
	.brightness_filter_node(bfn), .use_dac_freq(udf), .dac_code(dac), .mode(mode),
	.lamp_ignited(ign));
task chk(input string nm, input [7:0] e, input [7:0] g);
	n_tests++;
	if (g !== e) begin
		err_total++;
		$display("Error %0s exp %h got %h", nm, e, g);
	end
endtask
task summarize;
	$display("tests %0d errors %0d", n_tests, err_total);
	if (err_total == 0 && n_tests > 0) $display("Regression OK");
	else $display("Regression broken");
	$finish;
endtask
task cyc(input integer n);
	repeat (n) @(negedge clk);
endtask
// Bounded wait, a missing transition shows up in the following compare
task wait_mode(input [1:0] m, input integer lim);
	for (i = 0; i < lim && mode !== m; i++) @(negedge clk);
	chk("mode", {6'h0, m}, {6'h0, mode});
endtask
task t_delay;
	cyc(16370);
	chk("mode", 8'h00, {6'h0, mode});
	chk("drv", 8'h00, {6'h0, dpf, dps});
	wait_mode(2'h1, 40);
	chk("udf", 8'h01, {7'h0, udf});
	$display("delay test done");
endtask
task t_strike;
	ov = 1'b1;
	cyc(100);
	chk("mode", 8'h01, {6'h0, mode});
	chk("dac", 8'h33, dac);
	ov = 1'b0;
	lit = 1'b1;
	wait_mode(2'h2, 40);
	chk("run", 8'h02, {6'h0, ign, udf});
	$display("strike test done");
endtask
task t_run;
	cyc(9000);
	chk("mode", 8'h02, {6'h0, mode});
	lit = 1'b0;
	wait_mode(2'h3, 16400);
	chk("out", 8'h01, {5'h0, dpf, dps, bfn});
	lit = 1'b1;
	cyc(100);
	chk("mode", 8'h03, {6'h0, mode});
	$display("run test done");
endtask
task t_reenable;
	enable = 1'b0;
	cyc(2);
	chk("mode", 8'h00, {6'h0, mode});
	enable = 1'b1;
	t_delay;
	$display("reenable test done");
endtask
task t_dim;
	dsel = 1'b1;
	dedge = 1'b1;
	cyc(2100);
	chk("mode", 8'h02, {6'h0, mode});
	dedge = 1'b0;
	wait_mode(2'h3, 2100);
	chk("bfn", 8'h01, {7'h0, bfn});
	enable = 1'b0;
	dsel = 1'b0;
	cyc(2);
	enable = 1'b1;
	$display("dim test done");
endtask
initial begin
	cyc(8);
	rst_n = 1'b1;
	t_delay;
	t_strike;
	t_run;
	t_reenable;
	t_dim;
	summarize;
end
initial begin
	#8000000;
	err_total++;
	summarize;
end
endmodule // lamp_strike_run_fault_sequencer_tb_top
